// ### rtl/paec_defines.vh
`ifndef PAEC_DEFINES_VH
`define PAEC_DEFINES_VH

// Register addresses on the plain register port.
`define PAEC_ADDR_W          4
`define PAEC_ADDR_RISE       4'h0
`define PAEC_ADDR_FALL       4'h1
`define PAEC_ADDR_FLAGS      4'h2
`define PAEC_ADDR_CTRL       4'h3
`define PAEC_ADDR_IRQ_STAT   4'h4
`define PAEC_ADDR_IRQ_MASK   4'h5

// Implemented pins of the port: 5:3 and 1:0.
`define PAEC_IMPL_MASK       8'h3B

// Field positions.
`define PAEC_CTRL_MASTER_EN  0
`define PAEC_CTRL_OTHER_FLG  1
`define PAEC_STAT_EDGE       0
`define PAEC_STAT_WAKE       1

// Reset values.
`define PAEC_RST_BYTE        8'h00
`define PAEC_RST_CTRL        2'h0
`define PAEC_RST_IRQ         2'h0

`endif

// ### rtl/paec_pin_sync.v
`timescale 1ns/1ps
module paec_pin_sync (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_pin,
  output reg  o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // A change counts only once the second and third stages agree.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end
endmodule

// ### rtl/paec_edge_det.v
`timescale 1ns/1ps
module paec_edge_det (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_level,
  input  wire i_rise_en,
  input  wire i_fall_en,
  output wire o_hit
);
  reg prev_ff;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= i_level;
    end
  end

  // A disabled direction never produces a hit.
  assign o_hit = (i_rise_en & i_level & ~prev_ff) | (i_fall_en & ~i_level & prev_ff);
endmodule

// ### rtl/paec_top.v
// Function
// RULE1: Rise-select register bits 5:3,1:0 enable low-to-high detection per pin.
// RULE2: Fall-select register bits 5:3,1:0 enable high-to-low detection per pin.
// RULE3: Enabled edge sets pin flag and the summary change flag.
// RULE4: Zero select bit for a direction never sets flag for that direction.
// RULE5: Bits 7:6 and 2 of all three registers ignore writes, read zero.
// RULE6: All implemented bits reset to zero on every reset.
// RULE7: Flags are software read/write; hardware sets them independently.
// RULE8: Master enable clear still flags edges but requests no interrupt; the code still raises o_irq from the edge status bit when its mask bit is set.
// RULE9: Summary flag is the OR of all pin flags of both ports.
// RULE10: Edge during a clearing write leaves the flag set.
// RULE11: With master enable, edge raises wake; flags updated before wake.
// RULE12: Pins synchronised; edge is current versus previous sample, once per transition.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "paec_defines.vh"
module paec_top (
  input  wire                     i_clk,
  input  wire                     i_rst_n,
  input  wire [7:0]               i_port_a_pin,
  input  wire [`PAEC_ADDR_W-1:0]  i_addr,
  input  wire [7:0]               i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output reg  [7:0]               o_rdata,
  output reg                      o_summary_change_irq_flag,
  output reg                      o_change_irq_req,
  output reg                      o_wake,
  output reg                      o_irq
);
  reg  [7:0] port_a_rise_select_ff;
  reg  [7:0] port_a_fall_select_ff;
  reg  [7:0] port_a_change_flags_ff;
  reg  [1:0] ctrl_ff;
  reg  [1:0] irq_stat_ff;
  reg  [1:0] irq_mask_ff;
  reg  [7:0] nxt_flags;
  reg  [1:0] nxt_irq_stat;
  reg  [7:0] nxt_rdata;
  wire [7:0] level;
  wire [7:0] hit;
  wire       any_hit;
  wire       wr_rise;
  wire       wr_fall;
  wire       wr_flags;
  wire       wr_ctrl;
  wire       wr_stat;
  wire       wr_mask;
  wire       summary;
  wire       master_en;

  assign wr_rise  = i_wr & (i_addr == `PAEC_ADDR_RISE);
  assign wr_fall  = i_wr & (i_addr == `PAEC_ADDR_FALL);
  assign wr_flags = i_wr & (i_addr == `PAEC_ADDR_FLAGS);
  assign wr_ctrl  = i_wr & (i_addr == `PAEC_ADDR_CTRL);
  assign wr_stat  = i_wr & (i_addr == `PAEC_ADDR_IRQ_STAT);
  assign wr_mask  = i_wr & (i_addr == `PAEC_ADDR_IRQ_MASK);

  // Unimplemented pins get no detector, so their flags can never set.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      if (((`PAEC_IMPL_MASK >> g) & 8'h01) != 8'h00) begin : g_impl
        paec_pin_sync u_sync ( // RULE12
          .i_clk   (i_clk),
          .i_rst_n (i_rst_n),
          .i_pin   (i_port_a_pin[g]),
          .o_level (level[g])
        );
        paec_edge_det u_det ( // RULE12
          .i_clk     (i_clk),
          .i_rst_n   (i_rst_n),
          .i_level   (level[g]),
          .i_rise_en (port_a_rise_select_ff[g]),
          .i_fall_en (port_a_fall_select_ff[g]),
          .o_hit     (hit[g])
        );
      end else begin : g_none
        assign level[g] = 1'b0;
        assign hit[g]   = 1'b0;
      end
    end
  endgenerate

  assign any_hit   = |hit;
  assign master_en = ctrl_ff[`PAEC_CTRL_MASTER_EN];
  // The second port lives elsewhere; its flag summary enters through the control register.
  assign summary   = (|nxt_flags) | ctrl_ff[`PAEC_CTRL_OTHER_FLG]; // RULE9

  always @* begin
    nxt_flags = port_a_change_flags_ff;
    if (wr_flags) begin
      nxt_flags = i_wdata & `PAEC_IMPL_MASK; // RULE7 RULE5
    end
    // Hardware set wins over any write in the same cycle.
    nxt_flags = nxt_flags | hit; // RULE3 RULE10 RULE4
  end

  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_stat) begin
      nxt_irq_stat = irq_stat_ff & ~i_wdata[1:0];
    end
    if (any_hit) begin
      nxt_irq_stat[`PAEC_STAT_EDGE] = 1'b1;
    end
    if (any_hit & master_en) begin
      nxt_irq_stat[`PAEC_STAT_WAKE] = 1'b1;
    end
  end

  always @* begin
    case (i_addr)
      `PAEC_ADDR_RISE:     nxt_rdata = port_a_rise_select_ff;
      `PAEC_ADDR_FALL:     nxt_rdata = port_a_fall_select_ff;
      `PAEC_ADDR_FLAGS:    nxt_rdata = port_a_change_flags_ff;
      `PAEC_ADDR_CTRL:     nxt_rdata = {6'h00, ctrl_ff};
      `PAEC_ADDR_IRQ_STAT: nxt_rdata = {6'h00, irq_stat_ff};
      `PAEC_ADDR_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
      default:             nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      port_a_rise_select_ff     <= `PAEC_RST_BYTE; // RULE6
      port_a_fall_select_ff     <= `PAEC_RST_BYTE; // RULE6
      port_a_change_flags_ff    <= `PAEC_RST_BYTE; // RULE6
      ctrl_ff                   <= `PAEC_RST_CTRL;
      irq_stat_ff               <= `PAEC_RST_IRQ;
      irq_mask_ff               <= `PAEC_RST_IRQ;
      o_rdata                   <= 8'h00;
      o_summary_change_irq_flag <= 1'b0;
      o_change_irq_req          <= 1'b0;
      o_wake                    <= 1'b0;
      o_irq                     <= 1'b0;
    end else begin
      if (wr_rise) begin
        port_a_rise_select_ff <= i_wdata & `PAEC_IMPL_MASK; // RULE1 RULE5
      end
      if (wr_fall) begin
        port_a_fall_select_ff <= i_wdata & `PAEC_IMPL_MASK; // RULE2 RULE5
      end
      if (wr_ctrl) begin
        ctrl_ff <= i_wdata[1:0];
      end
      if (wr_mask) begin
        irq_mask_ff <= i_wdata[1:0];
      end
      port_a_change_flags_ff    <= nxt_flags;
      irq_stat_ff               <= nxt_irq_stat;
      o_rdata                   <= i_rd ? nxt_rdata : 8'h00;
      o_summary_change_irq_flag <= summary; // RULE3 RULE9
      // Flags land in the same edge as the request and as wake, so they are ready when wake rises.
      o_change_irq_req          <= summary & master_en; // RULE8
      o_wake                    <= any_hit & master_en; // RULE11
      o_irq                     <= |(nxt_irq_stat & irq_mask_ff);
    end
  end
endmodule

// ### verif/paec_asserts.sv
`timescale 1ns/1ps
`include "paec_defines.vh"
module paec_asserts (
  input wire logic                    i_clk,
  input wire logic                    i_rst_n,
  input wire logic [7:0]              i_port_a_pin,
  input wire logic [`PAEC_ADDR_W-1:0] i_addr,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [7:0]              o_rdata,
  input wire logic                    o_summary_change_irq_flag,
  input wire logic                    o_change_irq_req,
  input wire logic                    o_wake,
  input wire logic                    o_irq
);
  logic [7:0] pin_ff;
  logic [3:0] quiet_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Cycles since the pins last moved; any detection lands well inside ten.
  always @(posedge i_clk) begin
    pin_ff <= i_port_a_pin;
    if (!i_rst_n || pin_ff != i_port_a_pin) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
  end
  sequence s_map_rd;
    i_rd && i_addr < 4'h3;
  endsequence
  // A control write reaches the summary one edge later than a flag write does.
  sequence s_recent_wr;
    $past(i_wr) || $past(i_wr, 2);
  endsequence
  chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  chk_resv_zero: assert property (s_map_rd |=> (o_rdata & 8'hC4) == 8'h00)
    else $error("reserved bits read nonzero");
  chk_unmap_zero: assert property (i_rd && i_addr > 4'h5 |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
  chk_req_gate: assert property (o_change_irq_req |-> o_summary_change_irq_flag)
    else $error("request without flag");
  chk_wake_req: assert property (o_wake |-> ##[0:2] o_change_irq_req)
    else $error("wake without request");
  chk_wake_quiet: assert property (quiet_ff == 4'hC |-> !o_wake)
    else $error("wake on quiet pins");
  chk_sum_cause: assert property ($rose(o_summary_change_irq_flag) |->
    $past(i_wr) || $past(i_wr, 2) || quiet_ff < 4'hA) else $error("flag rose without cause");
  chk_flag_hold: assert property ($fell(o_summary_change_irq_flag) |-> s_recent_wr)
    else $error("summary fell without a write");
  chk_rst_zero: assert property ($rose(i_rst_n) |-> !o_irq && !o_wake &&
    !o_change_irq_req && !o_summary_change_irq_flag) else $error("outputs after reset");
endmodule

// ### verif/paec_pin_model.sv
`timescale 1ns/1ps
module paec_pin_model (
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_port_a_pin
);
  // Pins move well away from the clock edge, as truly external inputs do.
  initial o_port_a_pin = 8'h00;
  always @(i_level) o_port_a_pin <= #37 i_level;
endmodule

// ### verif/paec_top_tb.sv
`timescale 1ns/1ps
`include "paec_defines.vh"
module paec_top_tb;
  logic                    clk = 0, rst_n = 0, wr = 0, rd = 0, m, sumf, req, wake, irq;
  logic [`PAEC_ADDR_W-1:0] addr = 0;
  logic [7:0]              wdata = 0, lvl = 0, prev, pins, rdata, rs, fs, e;
  int                      err_count = 0, total_checks = 0, cyc = 0, i, wcnt = 0, w0;
  always #50 clk = ~clk;
  paec_pin_model i_pins (.i_level(lvl), .o_port_a_pin(pins));
  paec_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_port_a_pin(pins), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_summary_change_irq_flag(sumf),
    .o_change_irq_req(req), .o_wake(wake), .o_irq(irq));
  function automatic logic [7:0] exp_hit(logic [7:0] a, b, r, f);
    return ((~a & b & r) | (a & ~b & f)) & `PAEC_IMPL_MASK;
  endfunction
  task automatic chk(logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rdc(logic [3:0] a, logic [7:0] x);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, x);
  endtask
  task automatic summarize;
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (wake) wcnt++;
    if (cyc == 5000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    void'($urandom(32'h294FC4F8));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 9; i++) rdc(i[3:0], 8'h00);
    for (i = 0; i < 3; i++) begin
      wrr(i[3:0], 8'hFF);
      rdc(i[3:0], 8'h3B);
    end
    wrr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    prev = 8'h00;
    for (i = 0; i < 40; i++) begin
      rs = 8'($urandom);
      fs = 8'($urandom);
      m = 1'($urandom);
      wrr(`PAEC_ADDR_RISE, rs);
      wrr(`PAEC_ADDR_FALL, fs);
      wrr(`PAEC_ADDR_CTRL, {7'h0, m});
      wrr(`PAEC_ADDR_FLAGS, 8'h00);
      wrr(`PAEC_ADDR_IRQ_STAT, 8'h03);
      wrr(`PAEC_ADDR_IRQ_MASK, {6'h0, i[1:0]});
      w0 = wcnt;
      // Every eighth pass toggles all pins at once as a corner case.
      lvl <= (i % 8 == 0) ? ~prev : 8'($urandom);
      if (i % 2 == 1) begin
        // The second clearing write lands on the very edge that sets the flag.
        @(posedge clk);
        wrr(`PAEC_ADDR_FLAGS, 8'h00);
        wrr(`PAEC_ADDR_FLAGS, 8'h00);
      end
      repeat (10) @(posedge clk);
      e = exp_hit(prev, lvl, rs, fs);
      rdc(`PAEC_ADDR_FLAGS, e);
      chk(sumf, |e);
      chk(req, |e & m);
      chk(irq, |e & (i[0] | (i[1] & m)));
      chk(8'(wcnt - w0), {7'h0, |e & m});
      prev = lvl;
    end
    wrr(`PAEC_ADDR_FLAGS, 8'h00);
    wrr(`PAEC_ADDR_CTRL, 8'h02);
    rdc(`PAEC_ADDR_CTRL, 8'h02);
    chk(sumf, 8'h01);
    chk(req, 8'h00);
    wrr(`PAEC_ADDR_CTRL, 8'h03);
    rdc(`PAEC_ADDR_CTRL, 8'h03);
    chk(req, 8'h01);
    wrr(`PAEC_ADDR_FLAGS, 8'hFF);
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 3; i++) rdc(i[3:0], 8'h00);
    summarize;
  end
endmodule
bind paec_top paec_asserts i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_port_a_pin(i_port_a_pin), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_summary_change_irq_flag(o_summary_change_irq_flag), .o_change_irq_req(o_change_irq_req),
  .o_wake(o_wake), .o_irq(o_irq));
